// *** bench/eic_chk_assertions.sv ***
// Port-level assertions for the edge interrupt controller
`timescale 1ns/100ps
`default_nettype none
module eic_chk #(
  parameter NREQ = 4,
  parameter NPORT = 8,
  parameter NPER = 21
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_flag_clr,
  input wire logic [15:0] i_program_counter,
  input wire logic [15:0] i_stack_pointer,
  input wire logic i_return_from_exception,
  input wire logic [15:0] i_ret_ccr_word,
  input wire logic [NREQ+NPORT+NPER-1:0] o_flags,
  input wire logic o_mask_flag,
  input wire logic o_exc_busy,
  input wire logic [4:0] o_vector_num,
  input wire logic o_stack_we,
  input wire logic [15:0] o_stack_addr,
  input wire logic [15:0] o_stack_wdata,
  input wire logic o_vec_rd,
  input wire logic [15:0] o_vec_addr,
  input wire logic o_handler_go,
  input wire logic o_ccr_load,
  input wire logic [7:0] o_ccr_restore
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);
  property p_mask_entry;
    $rose(o_exc_busy) |-> o_mask_flag && !$past(o_mask_flag);
  endproperty
  a_mask_entry: assert property (p_mask_entry) else $error("mask not set on entry");
  property p_entry_len;
    $rose(o_exc_busy) |-> !o_handler_go [*8] ##7 o_handler_go && !o_exc_busy;
  endproperty
  a_entry_len: assert property (p_entry_len) else $error("entry length wrong");
  property p_pc_push;
    $rose(o_exc_busy) |-> o_stack_we && o_stack_wdata == $past(i_program_counter)
      && o_stack_addr == ($past(i_stack_pointer) & 16'hFFFE) - 16'h0002;
  endproperty
  a_pc_push: assert property (p_pc_push) else $error("bad first push");
  property p_ccr_push;
    $rose(o_exc_busy) |-> ##2 o_stack_we && o_stack_wdata[15:8] == o_stack_wdata[7:0]
      && !o_stack_addr[0];
  endproperty
  a_ccr_push: assert property (p_ccr_push) else $error("bad second push");
  property p_vec_addr;
    o_vec_rd |-> o_vec_addr == {10'h000, o_vector_num, 1'b0};
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong");
  property p_vec_two;
    $rose(o_vec_rd) |=> o_vec_rd ##1 !o_vec_rd;
  endproperty
  a_vec_two: assert property (p_vec_two) else $error("vector fetch not two");
  property p_ret;
    i_return_from_exception |=> o_ccr_load
      && {8'h00, o_ccr_restore} == ($past(i_ret_ccr_word) >> 8);
  endproperty
  a_ret: assert property (p_ret) else $error("bad ccr restore");
  property p_no_autoclr;
    ($past(o_flags) & ~o_flags) != 0 |-> $past(i_flag_clr);
  endproperty
  a_no_autoclr: assert property (p_no_autoclr) else $error("flag cleared by itself");
endmodule // eic_chk
bind eic_top eic_chk #(.NREQ(NREQ), .NPORT(NPORT), .NPER(NPER)) u_chk (.*);
`default_nettype wire

// *** bench/eic_cpu_model.sv ***
// CPU-side model: instruction ends and vector table reads
`timescale 1ns/100ps
`default_nettype none
module eic_cpu_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_vec_rd,
  input wire logic [15:0] i_vec_addr,
  output logic o_instr_end,
  output logic [15:0] o_vec_data
);
  logic [1:0] cnt_r;
  // Three-state instructions; short enough to keep entry inside budget
  always @(posedge i_clock) begin
    if (i_reset) begin
      cnt_r <= 2'h0;
      o_instr_end <= 1'b0;
      o_vec_data <= 16'h0000;
    end else begin
      cnt_r <= (cnt_r == 2'h2) ? 2'h0 : cnt_r + 2'h1;
      o_instr_end <= (cnt_r == 2'h2);
      // Stale table data is inverted so a late sample shows up
      o_vec_data <= i_vec_rd ? (16'hA000 | i_vec_addr) : ~o_vec_data;
    end
  end
endmodule // eic_cpu_model
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking bench for the edge interrupt controller
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic i_clock = 1'b0, i_reset = 1'b1, i_flag_clr = 1'b0, i_mask_we = 1'b0;
  logic i_mask_val = 1'b0, i_return_from_exception = 1'b0, i_instr_end;
  logic [3:0] i_edge_request_pins = 4'hF, i_req_pin_polarity_bits = 4'h2;
  logic [3:0] i_port_mode_reg_a = 4'h7, i_req_pin_enable_bits = 4'hF;
  logic [7:0] i_port_edge_pins = 8'hFF, i_port_pin_polarity_bits = 8'h80;
  logic [7:0] i_port_pin_enable_bits = 8'h00, i_condition_code_reg = 8'h3C;
  logic [20:0] i_periph_enable_bits = 21'h000000, i_periph_req = 21'h000000;
  logic [32:0] i_flag_clr_sel = 33'h000000000, o_flags;
  logic [15:0] i_program_counter = 16'h1234, i_stack_pointer = 16'h0FF3;
  logic [15:0] i_ret_ccr_word = 16'h0000, i_vec_data, o_stack_addr, o_stack_wdata;
  logic [15:0] o_stack_pointer_new, o_vec_addr, o_handler_addr;
  logic o_mask_flag, o_pending, o_exc_busy, o_stack_we, o_vec_rd, o_handler_go, o_ccr_load;
  logic [4:0] o_vector_num;
  logic [7:0] o_ccr_restore;
  int err_count = 0, comparisons = 0, cyc = 0;
  eic_top u_dut (.*);
  eic_cpu_model u_cpu (.i_clock(i_clock), .i_reset(i_reset), .i_vec_rd(o_vec_rd),
    .i_vec_addr(o_vec_addr), .o_instr_end(i_instr_end), .o_vec_data(i_vec_data));
  initial begin
    forever #12.5 i_clock = ~i_clock;
  end
  task automatic give_verdict;
    $display("mismatches %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard: the whole run needs well under a thousand cycles
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_count++;
      give_verdict;
    end
  end
  task automatic chk(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic clk(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // Called only while masked and long after any mode change
  task automatic clr(input logic [32:0] sel);
    @(posedge i_clock);
    i_flag_clr <= 1'b1;
    i_flag_clr_sel <= sel;
    @(posedge i_clock);
    i_flag_clr <= 1'b0;
    clk(1);
  endtask
  task automatic mask(input logic v);
    @(posedge i_clock);
    i_mask_we <= 1'b1;
    i_mask_val <= v;
    @(posedge i_clock);
    i_mask_we <= 1'b0;
  endtask
  task automatic take(input logic [4:0] vec);
    int n;
    logic pend;
    n = 0;
    pend = 1'b0;
    mask(1'b0);
    do begin
      @(negedge i_clock);
      n++;
      if (o_pending === 1'b1)
        pend = 1'b1;
    end while (o_handler_go !== 1'b1 && n < 27);
    chk("entry_time", n < 27, 1'b1);
    chk("pending_seen", pend, 1'b1);
    chk("pending_off", o_pending, 1'b0);
    chk("vector", o_vector_num, vec);
    chk("handler", o_handler_addr, 16'hA000 | {vec, 1'b0});
    chk("mask", o_mask_flag, 1'b1);
    chk("new_sp", o_stack_pointer_new, 16'h0FEE);
  endtask
  task automatic s_req;
    @(posedge i_clock);
    i_edge_request_pins <= 4'h4;
    clk(6);
    chk("req_edge", o_flags[3:0], 4'h1);
    @(posedge i_clock);
    i_port_mode_reg_a <= 4'hF;
    clk(6);
    chk("mode_on_low", o_flags[3:0], 4'h9);
    @(posedge i_clock);
    i_edge_request_pins <= 4'h6;
    clk(6);
    chk("rise", o_flags[3:0], 4'hB);
    take(5'h04);
    chk("kept", o_flags[3:0], 4'hB);
    clr(33'h000000001);
    chk("cleared", o_flags[3:0], 4'hA);
    take(5'h05);
    clr(33'h00000000F);
  endtask
  task automatic s_port;
    @(posedge i_clock);
    i_port_edge_pins <= 8'h7E;
    clk(6);
    chk("port_fall", o_flags[11:4], 8'h01);
    mask(1'b0);
    clk(20);
    chk("port_off", o_mask_flag, 1'b0);
    chk("port_no_pend", o_pending, 1'b0);
    mask(1'b1);
    @(posedge i_clock);
    i_port_edge_pins <= 8'hFE;
    i_port_pin_enable_bits <= 8'h01;
    clk(6);
    chk("port_rise", o_flags[11:4], 8'h81);
    take(5'h08);
    clr(33'h000000810);
  endtask
  task automatic s_per;
    @(posedge i_clock);
    i_periph_enable_bits <= 21'h100001;
    i_periph_req <= 21'h100001;
    @(posedge i_clock);
    i_periph_req <= 21'h000000;
    clk(2);
    chk("per_flags", o_flags[32:12], 21'h100001);
    take(5'h09);
    clr(33'h000001000);
    take(5'h17);
    clr(33'h100000000);
  endtask
  task automatic s_ret;
    @(posedge i_clock);
    i_ret_ccr_word <= 16'h5A81;
    i_return_from_exception <= 1'b1;
    @(posedge i_clock);
    i_return_from_exception <= 1'b0;
    @(negedge i_clock);
    chk("ccr_load", o_ccr_load, 1'b1);
    chk("ccr", o_ccr_restore, 8'h5A);
    chk("ret_mask", o_mask_flag, 1'b0);
  endtask
  initial begin
    clk(5);
    i_reset <= 1'b0;
    clk(4);
    chk("rst_flags", o_flags, 33'h000000000);
    chk("rst_mask", o_mask_flag, 1'b1);
    s_req;
    s_port;
    s_per;
    s_ret;
    give_verdict;
  end
endmodule // tb_top
`default_nettype wire

// *** rtl/eic_defs.vh ***
// Constants shared by the edge interrupt controller files
`ifndef EIC_DEFS_VH
`define EIC_DEFS_VH
`define EIC_NREQ 4
`define EIC_NPORT 8
`define EIC_NPER 21
`define EIC_NFLAG 33
`define EIC_NSRC 26
`define EIC_VEC_REQ0 5'h04
`define EIC_VEC_PORT 5'h08
`define EIC_VEC_PER_LO 5'h09
`define EIC_VEC_PER_SPAN 14
`define EIC_ST_STACK 4'h4
`define EIC_ST_VEC 4'h2
`define EIC_ST_FETCH 4'h4
`define EIC_ST_INT 4'h4
`define EIC_MASK_RST 1'b1
`define EIC_FLAG_RST 33'h000000000
`define EIC_PORT_EN_RST 8'h00
`define EIC_PMR_HOLD 2'h2
`define EIC_PC_OFS 16'h0002
`define EIC_CCR_OFS 16'h0004
`endif

// *** rtl/eic_edge_det.v ***
// Per-pin synchroniser and selectable edge detector
`timescale 1ns/100ps
`default_nettype none
module eic_edge_det #(
  parameter N = 4
) (
  input wire i_clock,
  input wire i_reset,
  input wire [N-1:0] i_pins,
  input wire [N-1:0] i_func,
  input wire [N-1:0] i_pol,
  output wire [N-1:0] o_hit
);
  reg [N-1:0] meta_r;
  reg [N-1:0] sync_r;
  reg [N-1:0] prev_r;
  wire [N-1:0] eff;
  // A pin not in interrupt function looks high, so switching function
  // on a low pin makes a false edge exactly as the hardware does
  assign eff = sync_r | ~i_func;
  always @(posedge i_clock) begin
    if (i_reset) begin
      meta_r <= {N{1'b1}};
      sync_r <= {N{1'b1}};
      prev_r <= {N{1'b1}};
    end else begin
      meta_r <= i_pins;
      sync_r <= meta_r;
      prev_r <= eff;
    end
  end
  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_bit
      assign o_hit[g] = i_pol[g] ? (~prev_r[g] & eff[g]) : (prev_r[g] & ~eff[g]);
    end
  endgenerate
endmodule // eic_edge_det
`default_nettype wire

// *** rtl/eic_prio.v ***
// Fixed-priority selector with vector number lookup
`timescale 1ns/100ps
`default_nettype none
`include "eic_defs.vh"
module eic_prio #(
  parameter N = `EIC_NSRC
) (
  input wire [N-1:0] i_req,
  output reg o_any,
  output reg [4:0] o_vec
);
  function [4:0] vec_of;
    input integer idx;
    integer t;
    begin
      t = 0;
      if (idx < `EIC_NREQ) begin
        vec_of = `EIC_VEC_REQ0 + idx[4:0];
      end else if (idx == `EIC_NREQ) begin
        vec_of = `EIC_VEC_PORT;
      end else begin
        t = ((idx - `EIC_NREQ - 1) * `EIC_VEC_PER_SPAN) / (`EIC_NPER - 1);
        vec_of = `EIC_VEC_PER_LO + t[4:0];
      end
    end
  endfunction
  integer i;
  // Lowest index wins; it is scanned last so it overwrites the others
  always @* begin
    o_any = 1'b0;
    o_vec = 5'h00;
    for (i = N - 1; i >= 0; i = i - 1) begin
      if (i_req[i]) begin
        o_any = 1'b1;
        o_vec = vec_of(i);
      end
    end
  end
endmodule // eic_prio
`default_nettype wire

// *** rtl/eic_top.v ***
// Edge interrupt controller with exception entry sequencer
// How it works
// - Request pins use per-pin rising or falling edge from polarity bits.
// - Request pin flag sets on chosen edge in interrupt function or when a function bit change on a low pin makes the chosen edge.
// - Per-source enable gates recognition; mask flag blocks all.
// - Request pins use vectors 7 to 4; pin 0 highest priority.
// - Port edge pins use per-pin rising or falling edge selection.
// - Port edge request recognised only when its enable bit is 1.
// - All port edge pins share vector 8; software reads flags.
// - Port edge flags set even when pin works as general port.
// - 21 peripheral requests latched, enabled, vectors 23 down to 9.
// - Highest-priority pending flag selected, others stay pending.
// - Accept only with mask flag 0, else request stays pending.
// - After current instruction, push program counter and condition codes.
// - Acceptance sets the global mask flag to 1.
// - Vector address generated, handler address fetched and started.
// - A request colliding with a clear is taken after the instruction.
// - Entry takes wait, 4 stack, 2 vector, 4 fetch, 4 internal states.
// - Stack word accesses force address bit 0 to 0.
// - Condition codes stacked as full word; return reloads even byte.
// - Function bit 0 to 1 on low pin, falling edge, sets flag.
// - Function bit 1 to 0 on low pin, rising edge, sets flag.
// - Request pin flag clear right after port mode write is ignored.
// - Flags clear only by writing 0; acceptance leaves them set.
// - Port edge enables reset to all zeros.
`timescale 1ns/100ps
`default_nettype none
`include "eic_defs.vh"
module eic_top #(
  parameter NREQ = `EIC_NREQ,
  parameter NPORT = `EIC_NPORT,
  parameter NPER = `EIC_NPER
) (
  input wire i_clock,
  input wire i_reset,
  input wire [NREQ-1:0] i_edge_request_pins,
  input wire [NPORT-1:0] i_port_edge_pins,
  input wire [NREQ-1:0] i_req_pin_polarity_bits,
  input wire [NPORT-1:0] i_port_pin_polarity_bits,
  input wire [NREQ-1:0] i_port_mode_reg_a,
  input wire [NREQ-1:0] i_req_pin_enable_bits,
  input wire [NPORT-1:0] i_port_pin_enable_bits,
  input wire [NPER-1:0] i_periph_enable_bits,
  input wire [NPER-1:0] i_periph_req,
  input wire i_flag_clr,
  input wire [NREQ+NPORT+NPER-1:0] i_flag_clr_sel,
  input wire i_instr_end,
  input wire [15:0] i_program_counter,
  input wire [15:0] i_stack_pointer,
  input wire [7:0] i_condition_code_reg,
  input wire [15:0] i_vec_data,
  input wire i_mask_we,
  input wire i_mask_val,
  input wire i_return_from_exception,
  input wire [15:0] i_ret_ccr_word,
  output reg [NREQ+NPORT+NPER-1:0] o_flags,
  output reg o_mask_flag,
  output reg o_pending,
  output reg o_exc_busy,
  output reg [4:0] o_vector_num,
  output reg o_stack_we,
  output reg [15:0] o_stack_addr,
  output reg [15:0] o_stack_wdata,
  output reg [15:0] o_stack_pointer_new,
  output reg o_vec_rd,
  output reg [15:0] o_vec_addr,
  output reg o_handler_go,
  output reg [15:0] o_handler_addr,
  output reg o_ccr_load,
  output reg [7:0] o_ccr_restore
);
  localparam NF = NREQ + NPORT + NPER;
  localparam NS = NREQ + 1 + NPER;
  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_STACK = 5'h02;
  localparam [4:0] S_VEC = 5'h04;
  localparam [4:0] S_FETCH = 5'h08;
  localparam [4:0] S_INT = 5'h10;

  reg [4:0] state_r;
  reg [4:0] state_nxt;
  reg [3:0] cnt_r;
  reg [3:0] cnt_nxt;
  reg [NF-1:0] flags_nxt;
  reg mask_nxt;
  reg [4:0] vec_nxt;
  reg stack_we_nxt;
  reg [15:0] stack_addr_nxt;
  reg [15:0] stack_wdata_nxt;
  reg [15:0] sp_new_nxt;
  reg vec_rd_nxt;
  reg [15:0] vec_addr_nxt;
  reg go_nxt;
  reg [15:0] handler_nxt;
  reg [15:0] handler_r;
  reg [NREQ-1:0] pmr_prev_r;
  reg [1:0] pmr_hold_r;
  reg [1:0] pmr_hold_nxt;
  reg [NREQ-1:0] req_en_r;
  reg [NPORT-1:0] port_en_r;
  reg [NPER-1:0] per_en_r;

  wire [NREQ-1:0] req_hit;
  wire [NPORT-1:0] port_hit;
  wire [NF-1:0] set_vec;
  wire [NF-1:0] clr_vec;
  wire [NS-1:0] src_req;
  wire sel_any;
  wire [4:0] sel_vec;
  wire accept;
  wire [15:0] sp_even;

  eic_edge_det #(
    .N(NREQ)
  ) u_req_edge (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pins(i_edge_request_pins),
    .i_func(i_port_mode_reg_a),
    .i_pol(i_req_pin_polarity_bits),
    .o_hit(req_hit)
  );

  // Port edge pins have no function gate, so driven port edges count too
  eic_edge_det #(
    .N(NPORT)
  ) u_port_edge (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_pins(i_port_edge_pins),
    .i_func({NPORT{1'b1}}),
    .i_pol(i_port_pin_polarity_bits),
    .o_hit(port_hit)
  );

  assign set_vec = {i_periph_req, port_hit, req_hit};

  // A port mode change opens a window of two instruction ends in which
  // clearing the request pin flags does nothing
  assign clr_vec = i_flag_clr ?
    (i_flag_clr_sel & ~{{(NPORT+NPER){1'b0}}, {NREQ{pmr_hold_r != 2'h0}}}) : {NF{1'b0}};

  always @* begin
    pmr_hold_nxt = pmr_hold_r;
    if (pmr_prev_r != i_port_mode_reg_a) begin
      pmr_hold_nxt = `EIC_PMR_HOLD;
    end else if (i_instr_end && pmr_hold_r != 2'h0) begin
      pmr_hold_nxt = pmr_hold_r - 2'h1;
    end
  end

  // Set wins over a clear in the same cycle; acceptance never clears
  always @* begin
    flags_nxt = (o_flags & ~clr_vec) | set_vec;
  end

  assign src_req = {o_flags[NF-1:NREQ+NPORT] & per_en_r,
    |(o_flags[NREQ+NPORT-1:NREQ] & port_en_r),
    o_flags[NREQ-1:0] & req_en_r};

  eic_prio #(
    .N(NS)
  ) u_prio (
    .i_req(src_req),
    .o_any(sel_any),
    .o_vec(sel_vec)
  );

  // Decision only at an instruction boundary, on the registered flags; a clearing write in that same cycle is not yet seen
  assign accept = (state_r == S_IDLE) && sel_any && !o_mask_flag && i_instr_end;
  assign sp_even = {i_stack_pointer[15:1], 1'b0};

  always @* begin
    mask_nxt = o_mask_flag;
    if (accept) begin
      mask_nxt = 1'b1;
    end else if (i_return_from_exception) begin
      mask_nxt = i_ret_ccr_word[15];
    end else if (i_mask_we) begin
      mask_nxt = i_mask_val;
    end
  end

  always @* begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    vec_nxt = o_vector_num;
    stack_we_nxt = 1'b0;
    stack_addr_nxt = o_stack_addr;
    stack_wdata_nxt = o_stack_wdata;
    sp_new_nxt = o_stack_pointer_new;
    vec_rd_nxt = 1'b0;
    vec_addr_nxt = o_vec_addr;
    go_nxt = 1'b0;
    handler_nxt = handler_r;
    case (state_r)
      S_IDLE: begin
        if (accept) begin
          state_nxt = S_STACK;
          cnt_nxt = `EIC_ST_STACK - 4'h1;
          vec_nxt = sel_vec;
          stack_we_nxt = 1'b1;
          stack_addr_nxt = sp_even - `EIC_PC_OFS;
          stack_wdata_nxt = i_program_counter;
          sp_new_nxt = sp_even - `EIC_CCR_OFS;
        end
      end
      S_STACK: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h2) begin
          stack_we_nxt = 1'b1;
          stack_addr_nxt = o_stack_pointer_new;
          stack_wdata_nxt = {i_condition_code_reg, i_condition_code_reg};
        end
        if (cnt_r == 4'h0) begin
          state_nxt = S_VEC;
          cnt_nxt = `EIC_ST_VEC - 4'h1;
          vec_rd_nxt = 1'b1;
          vec_addr_nxt = {10'h000, o_vector_num, 1'b0};
        end
      end
      S_VEC: begin
        cnt_nxt = cnt_r - 4'h1;
        vec_rd_nxt = (cnt_r != 4'h0);
        if (cnt_r == 4'h0) begin
          handler_nxt = i_vec_data;
          state_nxt = S_FETCH;
          cnt_nxt = `EIC_ST_FETCH - 4'h1;
        end
      end
      S_FETCH: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          state_nxt = S_INT;
          cnt_nxt = `EIC_ST_INT - 4'h1;
        end
      end
      S_INT: begin
        cnt_nxt = cnt_r - 4'h1;
        if (cnt_r == 4'h0) begin
          state_nxt = S_IDLE;
          cnt_nxt = 4'h0;
          go_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = S_IDLE;
        cnt_nxt = 4'h0;
      end
    endcase
  end

  always @(posedge i_clock) begin
    if (i_reset) begin
      state_r <= S_IDLE;
      cnt_r <= 4'h0;
      o_flags <= `EIC_FLAG_RST;
      o_mask_flag <= `EIC_MASK_RST;
      o_pending <= 1'b0;
      o_exc_busy <= 1'b0;
      o_vector_num <= 5'h00;
      o_stack_we <= 1'b0;
      o_stack_addr <= 16'h0000;
      o_stack_wdata <= 16'h0000;
      o_stack_pointer_new <= 16'h0000;
      o_vec_rd <= 1'b0;
      o_vec_addr <= 16'h0000;
      o_handler_go <= 1'b0;
      o_handler_addr <= 16'h0000;
      handler_r <= 16'h0000;
      o_ccr_load <= 1'b0;
      o_ccr_restore <= 8'h00;
      pmr_prev_r <= {NREQ{1'b0}};
      pmr_hold_r <= 2'h0;
      req_en_r <= {NREQ{1'b0}};
      port_en_r <= `EIC_PORT_EN_RST;
      per_en_r <= {NPER{1'b0}};
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      o_flags <= flags_nxt;
      o_mask_flag <= mask_nxt;
      o_pending <= sel_any && !o_mask_flag;
      o_exc_busy <= (state_nxt != S_IDLE);
      o_vector_num <= vec_nxt;
      o_stack_we <= stack_we_nxt;
      o_stack_addr <= stack_addr_nxt;
      o_stack_wdata <= stack_wdata_nxt;
      o_stack_pointer_new <= sp_new_nxt;
      o_vec_rd <= vec_rd_nxt;
      o_vec_addr <= vec_addr_nxt;
      o_handler_go <= go_nxt;
      o_handler_addr <= go_nxt ? handler_r : o_handler_addr;
      handler_r <= handler_nxt;
      // Only the even-address byte returns; the odd copy is dropped
      o_ccr_load <= i_return_from_exception;
      o_ccr_restore <= i_return_from_exception ? i_ret_ccr_word[15:8] : o_ccr_restore;
      pmr_prev_r <= i_port_mode_reg_a;
      pmr_hold_r <= pmr_hold_nxt;
      req_en_r <= i_req_pin_enable_bits;
      port_en_r <= i_port_pin_enable_bits;
      per_en_r <= i_periph_enable_bits;
    end
  end
endmodule // eic_top
`default_nettype wire
